// ===== verif/scr_synth_cfg_tb.sv
// Self-checking testbench for the synthesizer configuration registers
`timescale 1ns/1ps
module testbench;
   import scr_pkg::*;
   // Clock, reset and register port drive
   logic                        clock;
   logic                        rst;
   logic [ADDR_W-1:0]           reg_addr;
   logic                        reg_wr;
   logic                        reg_rd;
   logic [7:0]                  reg_wdata;
   logic [7:0]                  reg_rdata;
   logic                        reg_rvalid;
   logic [15:0]                 base_hz;
   logic [15:0]                 base_mul;
   // Observed configuration outputs
   logic [15:0]                 fec_num;
   logic [15:0]                 fec_den;
   logic [RATE_W-1:0]           rate_prod;
   logic                        a_src;
   logic                        b_src;
   logic                        a_en;
   logic                        b_en;
   logic [1:0]                  a_crit;
   logic [1:0]                  b_crit;
   logic [3:0]                  a_lim;
   logic [3:0]                  a_win;
   logic [3:0]                  b_lim;
   logic [3:0]                  b_win;
   logic signed [NUM_SYNTH-1:0][31:0] trim;
   // Bookkeeping
   int                          n_fail;
   int                          n_tests;
   // Reset image of every mapped byte, in address order
   logic [ADDR_W-1:0] rst_addr [11] = '{7'h64, 7'h65, 7'h66, 7'h67, 7'h70, 7'h71,
                                         7'h72, 7'h73, 7'h74, 7'h75, 7'h76};
   logic [7:0]        rst_byte [11] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h10, 8'h01,
                                         8'hAA, 8'h04, 8'h6A, 8'hAA, 8'hAB};

   scr_synth_cfg i_dut (
      .clock                   (clock),
      .rst                     (rst),
      .reg_addr                (reg_addr),
      .reg_wr                  (reg_wr),
      .reg_rd                  (reg_rd),
      .reg_wdata               (reg_wdata),
      .reg_rdata               (reg_rdata),
      .reg_rvalid              (reg_rvalid),
      .base_rate_hz            (base_hz),
      .base_rate_multiplier    (base_mul),
      .synth_b_fec_numerator   (fec_num),
      .synth_b_fec_denominator (fec_den),
      .synth_b_rate_product    (rate_prod),
      .synth_a_loop_source     (a_src),
      .synth_b_loop_source     (b_src),
      .synth_a_out_en          (a_en),
      .synth_b_out_en          (b_en),
      .loop_a_lock_criterion   (a_crit),
      .loop_b_lock_criterion   (b_crit),
      .loop_a_phase_limit_us   (a_lim),
      .loop_a_window_s         (a_win),
      .loop_b_phase_limit_us   (b_lim),
      .loop_b_window_s         (b_win),
      .synth_rate_trim         (trim)
   );

   // Clock of 100 ns period
   always #50 clock = ~clock;

   // Compare and count
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk

   // Verdict and end of run
   task automatic finish_test();
      if (n_fail == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   // One-cycle write strobe; register outputs are settled when this returns, lock figures and rate product later
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clock);
      #10 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #10 reg_wr = 1'b0;
   endtask : wr

   // One-cycle read strobe; answer valid for exactly one cycle
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge clock);
      #10 reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clock);
      #10 reg_rd = 1'b0;
      chk(reg_rvalid, 1'b1);
      chk(reg_rdata, e);
      @(posedge clock);
      #10 chk(reg_rvalid, 1'b0);
   endtask : rd

   // Reset image of registers and outputs
   task automatic t_reset();
      for (int i = 0; i < 11; i++) rd(rst_addr[i], rst_byte[i]);
      chk({fec_num, fec_den}, FEC_RST);
      chk({b_src, a_src, a_en, b_en}, 4'hA);
      chk({a_crit, b_crit}, 4'hA);
      chk({a_lim, a_win, b_lim, b_win}, 16'hA1A1);
      for (int i = 0; i < NUM_SYNTH; i++) chk(trim[i], TRIM_RST);
      rd(7'h68, 8'h00);
   endtask : t_reset

   // FEC ratio fields and the numerator-side rate product
   task automatic t_fec();
      wr(7'h64, 8'h00);
      wr(7'h65, 8'hFF);
      wr(7'h66, 8'h00);
      wr(7'h67, 8'hED);
      chk(fec_num, 16'h00FF);
      chk(fec_den, 16'h00ED);
      repeat (2) @(posedge clock);
      #10 chk(rate_prod, 64'd40000 * 64'd1944 * 64'd8 * 64'd255);
      base_hz = 16'h61A8;
      base_mul = 16'h0C35;
      repeat (3) @(posedge clock);
      #10 chk(rate_prod, 64'd25000 * 64'd3125 * 64'd8 * 64'd255);
      rd(7'h65, 8'hFF);
   endtask : t_fec

   // Loop source and output gating, reserved bits held
   task automatic t_src_en();
      wr(7'h70, 8'hEF);
      chk({a_src, b_src}, 2'b10);
      rd(7'h70, 8'h01);
      wr(7'h70, 8'h10);
      chk({a_src, b_src}, 2'b01);
      wr(7'h71, 8'h04);
      chk({a_en, b_en}, 2'b01);
      wr(7'h71, 8'hFB);
      chk({a_en, b_en}, 2'b10);
      rd(7'h71, 8'h01);
      wr(7'h71, 8'h05);
      chk({a_en, b_en}, 2'b11);
   endtask : t_src_en

   // Every valid lock criterion code on both loops, then reserved code on loop A
   task automatic t_lock();
      logic [1:0] ca;
      logic [1:0] cb;
      for (int c = 1; c <= 3; c++) begin
         ca = 2'(c);
         cb = 2'(4 - c);
         wr(7'h72, {4'h0, cb, ca});
         chk({a_crit, b_crit}, {ca, cb});
         repeat (2) @(posedge clock);
         #10 chk({a_lim, a_win}, {(ca == 2'b01) ? 4'h1 : 4'hA,
                                  (ca == 2'b11) ? 4'hA : 4'h1});
         chk({b_lim, b_win}, {(cb == 2'b01) ? 4'h1 : 4'hA,
                              (cb == 2'b11) ? 4'hA : 4'h1});
         rd(7'h72, {4'hA, cb, ca});
      end
      wr(7'h72, 8'hF4);
      repeat (2) @(posedge clock);
      #10 chk({a_crit, a_lim, a_win}, {2'b00, 4'hA, 4'hA});
      chk({b_crit, b_lim, b_win}, {2'b01, 4'h1, 4'h1});
   endtask : t_lock

   // Negative trim, byte by byte, reaches all synthesizers
   task automatic t_trim();
      // Fast oscillator by two percent gives a small negative trim
      wr(7'h73, 8'hFA);
      wr(7'h74, 8'hFA);
      wr(7'h75, 8'hFA);
      wr(7'h76, 8'hFB);
      for (int i = 0; i < NUM_SYNTH; i++) chk(trim[i], 32'hFAFAFAFB);
      chk($signed(trim[3]) < 0, 1'b1);
      rd(7'h76, 8'hFB);
      wr(7'h73, 8'h05);
      chk(trim[2], 32'h05FAFAFB);
   endtask : t_trim

   // Watchdog against a hang
   initial begin
      #1000000;
      n_fail++;
      finish_test();
   end

   // Main sequence
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      reg_addr = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = '0;
      base_hz = 16'h9C40;
      base_mul = 16'h0798;
      n_fail = 0;
      n_tests = 0;
      repeat (8) @(posedge clock);
      #10 rst = 1'b0;
      t_reset();
      t_fec();
      t_src_en();
      t_lock();
      t_trim();
      finish_test();
   end
endmodule : testbench

// ===== verilog/scr_cfg_if.sv
// Carrier between the register file and its two helper modules
`timescale 1ns/1ps
interface scr_cfg_if;
   import scr_pkg::*;
   logic [15:0]           fec_num;   // FEC numerator
   logic [15:0]           fec_den;   // FEC denominator
   logic [15:0]           base_hz;   // Base rate in Hz
   logic [15:0]           base_mul;  // Base multiplier
   logic [RATE_W-1:0]     rate_num;  // Base x mult x 8 x numerator
   logic [1:0][1:0]       crit;      // Lock criterion per loop
   logic [1:0][3:0]       lim_us;    // Phase limit in us per loop
   logic [1:0][3:0]       win_s;     // Window in s per loop
   modport regs (output fec_num, fec_den, base_hz, base_mul, crit,
                 input rate_num, lim_us, win_s);
   modport rate (input fec_num, fec_den, base_hz, base_mul, output rate_num);
   modport lock (input crit, output lim_us, win_s);
endinterface : scr_cfg_if

// ===== verilog/scr_lock_decode.sv
// Turns each loop's lock criterion code into a phase limit and window
`timescale 1ns/1ps
module scr_lock_decode
   import scr_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Configuration carrier
   scr_cfg_if.lock   cfg
);
   logic [1:0][3:0] lim_q, lim_d; // Phase limit in us
   logic [1:0][3:0] win_q, win_d; // Window in s

   // Limit and window of a code; reserved code keeps the old figures
   function automatic logic [7:0] crit_fig(input logic [1:0] c, input logic [7:0] old);
      case (scr_lock_type'(c))
         LK_1US_1S:   crit_fig = {4'h1, 4'h1};
         LK_10US_1S:  crit_fig = {4'hA, 4'h1};
         LK_10US_10S: crit_fig = {4'hA, 4'hA};
         default:     crit_fig = old;
      endcase
   endfunction : crit_fig

   // Next figures, one decoder per loop
   for (genvar g = 0; g < 2; g++) begin : g_loop
      always_comb begin
         {lim_d[g], win_d[g]} = crit_fig(cfg.crit[g], {lim_q[g], win_q[g]});
      end
   end

   // Registered figures
   always_ff @(posedge clock) begin
      if (rst) begin
         lim_q <= {LIM_RST_US, LIM_RST_US};
         win_q <= {WIN_RST_S, WIN_RST_S};
      end else begin
         lim_q <= lim_d;
         win_q <= win_d;
      end
   end

   assign cfg.lim_us = lim_q;
   assign cfg.win_s  = win_q;

   // Tight code gives 1 us over 1 s
   a_lock_tight: assert property (@(posedge clock) disable iff (rst)
      cfg.crit[0] == LK_1US_1S |=> lim_q[0] == 4'h1 && win_q[0] == 4'h1)
      else $error("Loop A tight criterion not decoded");
   // Long code gives 10 us over 10 s
   a_lock_long: assert property (@(posedge clock) disable iff (rst)
      cfg.crit[1] == LK_10US_10S |=> lim_q[1] == 4'hA && win_q[1] == 4'hA)
      else $error("Loop B long criterion not decoded");
   // Reserved code leaves figures untouched
   a_lock_resv: assert property (@(posedge clock) disable iff (rst)
      cfg.crit[0] == LK_RESERVED |=> $stable(lim_q[0]) && $stable(win_q[0]))
      else $error("Reserved lock code changed figures");
endmodule : scr_lock_decode

// ===== verilog/scr_pkg.sv
// Constants shared by the synthesizer configuration block
package scr_pkg;
   localparam int          ADDR_W      = 7;
   localparam int          RATE_W      = 51;  // 16 x 16 x 16 plus three bits for x8
   localparam int          NUM_SYNTH   = 4;   // Synthesizers that share the trim
   localparam int          SYNTH_SHIFT = 3;   // Multiply by eight
   localparam int          TRIM_FRAC   = 32;  // Trim step is 2^-TRIM_FRAC of nominal
   // Register offsets
   localparam logic [6:0]  FEC_ADDR    = 7'h64;
   localparam logic [6:0]  SRC_ADDR    = 7'h70;
   localparam logic [6:0]  OEN_ADDR    = 7'h71;
   localparam logic [6:0]  LOCK_ADDR   = 7'h72;
   localparam logic [6:0]  TRIM_ADDR   = 7'h73;
   // Reset values
   localparam logic [31:0] FEC_RST     = 32'h00010001;
   localparam logic [7:0]  SRC_RST     = 8'h10;
   localparam logic [7:0]  OEN_RST     = 8'h01;
   localparam logic [7:0]  LOCK_RST    = 8'hAA;
   localparam logic [31:0] TRIM_RST    = 32'h046AAAAB;
   // Writable bits; the rest are reserved
   localparam logic [7:0]  SRC_WMASK   = 8'h11;
   localparam logic [7:0]  OEN_WMASK   = 8'h05;
   localparam logic [7:0]  LOCK_WMASK  = 8'h0F;
   // Field positions
   localparam int          FEC_NUM_LSB = 16;
   localparam int          SRC_A_BIT   = 0;
   localparam int          SRC_B_BIT   = 4;
   localparam int          OEN_A_BIT   = 0;
   localparam int          OEN_B_BIT   = 2;
   localparam int          LOCK_A_LSB  = 0;
   localparam int          LOCK_B_LSB  = 2;
   // Lock figures after reset
   localparam logic [3:0]  LIM_RST_US  = 4'hA;
   localparam logic [3:0]  WIN_RST_S   = 4'h1;
   // Lock criterion codes
   typedef enum logic [1:0] {
      LK_RESERVED = 2'b00,
      LK_1US_1S   = 2'b01,
      LK_10US_1S  = 2'b10,
      LK_10US_10S = 2'b11
   } scr_lock_type;
endpackage : scr_pkg

// ===== verilog/scr_rate_calc.sv
// Two-stage product of base rate, multiplier, eight and FEC numerator
`timescale 1ns/1ps
module scr_rate_calc
   import scr_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Configuration carrier
   scr_cfg_if.rate   cfg
);
   logic [31:0]       p1_q, p1_d;     // Base x multiplier
   logic [15:0]       num_q, num_d;   // Numerator aligned with p1
   logic [RATE_W-1:0] rate_q, rate_d; // Full product

   // Next values of the multiply pipeline
   always_comb begin
      p1_d   = 32'(cfg.base_hz) * 32'(cfg.base_mul);
      num_d  = cfg.fec_num;
      // Widen before multiplying; a bare product in a concatenation keeps only 32 bits
      rate_d = RATE_W'({48'(p1_q) * 48'(num_q), 3'b000});
   end

   // Pipeline registers
   always_ff @(posedge clock) begin
      if (rst) begin
         p1_q   <= 32'h00000000;
         num_q  <= 16'h0000;
         rate_q <= '0;
      end else begin
         p1_q   <= p1_d;
         num_q  <= num_d;
         rate_q <= rate_d;
      end
   end

   assign cfg.rate_num = rate_q;

   // Product two cycles after its operands
   a_rate_product: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && !$past(rst, 2) |-> cfg.rate_num == RATE_W'(8 * 64'($past(cfg.base_hz, 2))
      * 64'($past(cfg.base_mul, 2)) * 64'($past(cfg.fec_num, 2))))
      else $error("Synth B rate product wrong");
endmodule : scr_rate_calc

// ===== verilog/scr_synth_cfg.sv
// Synthesizer configuration registers on the serial management port
`timescale 1ns/1ps
module scr_synth_cfg
   import scr_pkg::*;
(
   // Clock and reset
   input  wire logic                    clock,
   input  wire logic                    rst,
   // Byte register access from the serial port engine
   input  wire logic [ADDR_W-1:0]       reg_addr,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   input  wire logic [7:0]              reg_wdata,
   output logic      [7:0]              reg_rdata,
   output logic                         reg_rvalid,
   // Base rate settings held elsewhere
   input  wire logic [15:0]             base_rate_hz,
   input  wire logic [15:0]             base_rate_multiplier,
   // Synthesizer B rate settings
   output logic      [15:0]             synth_b_fec_numerator,
   output logic      [15:0]             synth_b_fec_denominator,
   output logic      [RATE_W-1:0]       synth_b_rate_product,
   // Loop source and output gating
   output logic                         synth_a_loop_source,
   output logic                         synth_b_loop_source,
   output logic                         synth_a_out_en,
   output logic                         synth_b_out_en,
   // Lock criteria
   output logic      [1:0]              loop_a_lock_criterion,
   output logic      [1:0]              loop_b_lock_criterion,
   output logic      [3:0]              loop_a_phase_limit_us,
   output logic      [3:0]              loop_a_window_s,
   output logic      [3:0]              loop_b_phase_limit_us,
   output logic      [3:0]              loop_b_window_s,
   // Centre rate trim, one copy per synthesizer
   output logic signed [NUM_SYNTH-1:0][31:0] synth_rate_trim
);
   // Register storage
   logic [31:0] fec_q,  fec_d;   // FEC ratio
   logic [7:0]  src_q,  src_d;   // Loop source select
   logic [7:0]  oen_q,  oen_d;   // Output enables
   logic [7:0]  lock_q, lock_d;  // Lock criterion select
   logic [31:0] trim_q, trim_d;  // Oscillator rate trim
   // Read return
   logic [7:0]  rdata_q, rdata_d;
   logic        rvalid_q, rvalid_d;
   // Per-synthesizer trim copies
   logic signed [NUM_SYNTH-1:0][31:0] trim_bc_q;

   // Carrier to the helpers
   scr_cfg_if cfg ();

   // Parameter sanity, refused at elaboration
   if (RATE_W < 51) begin : g_rate_w_chk
      $error("Rate product too narrow");
   end

   // Byte lane of a 32-bit register, lowest address holds the top byte
   function automatic int lane_of(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] base);
      logic [1:0] idx;
      idx = 2'(a - base);
      lane_of = 3 - int'(idx);
   endfunction : lane_of

   // True when the address lies in a four-byte register
   function automatic logic in_word(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base);
      in_word = (a >= base) && (a <= base + 7'h03);
   endfunction : in_word

   // Merge written byte with reserved reset bits
   function automatic logic [7:0] keep_resv(input logic [7:0] w,
                                            input logic [7:0] rstv,
                                            input logic [7:0] msk);
      keep_resv = (w & msk) | (rstv & ~msk);
   endfunction : keep_resv

   // Next register contents and read data
   always_comb begin
      fec_d    = fec_q;
      src_d    = src_q;
      oen_d    = oen_q;
      lock_d   = lock_q;
      trim_d   = trim_q;
      rdata_d  = rdata_q;
      rvalid_d = reg_rd;
      // Writes; unmapped addresses are ignored
      if (reg_wr) begin
         if (in_word(reg_addr, FEC_ADDR)) begin
            // Numerator high half, denominator low half
            fec_d[lane_of(reg_addr, FEC_ADDR)*8 +: 8] = reg_wdata;
         end else if (in_word(reg_addr, TRIM_ADDR)) begin
            trim_d[lane_of(reg_addr, TRIM_ADDR)*8 +: 8] = reg_wdata;
         end else if (reg_addr == SRC_ADDR) begin
            src_d = keep_resv(reg_wdata, SRC_RST, SRC_WMASK);
         end else if (reg_addr == OEN_ADDR) begin
            oen_d = keep_resv(reg_wdata, OEN_RST, OEN_WMASK);
         end else if (reg_addr == LOCK_ADDR) begin
            lock_d = keep_resv(reg_wdata, LOCK_RST, LOCK_WMASK);
         end
      end
      // Reads; unmapped addresses return zero
      if (reg_rd) begin
         if (in_word(reg_addr, FEC_ADDR)) begin
            rdata_d = fec_q[lane_of(reg_addr, FEC_ADDR)*8 +: 8];
         end else if (in_word(reg_addr, TRIM_ADDR)) begin
            rdata_d = trim_q[lane_of(reg_addr, TRIM_ADDR)*8 +: 8];
         end else if (reg_addr == SRC_ADDR) begin
            rdata_d = src_q;
         end else if (reg_addr == OEN_ADDR) begin
            rdata_d = oen_q;
         end else if (reg_addr == LOCK_ADDR) begin
            rdata_d = lock_q;
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   // Register file flops
   always_ff @(posedge clock) begin
      if (rst) begin
         fec_q    <= FEC_RST;
         src_q    <= SRC_RST;
         oen_q    <= OEN_RST;
         lock_q   <= LOCK_RST;
         trim_q   <= TRIM_RST;
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         fec_q    <= fec_d;
         src_q    <= src_d;
         oen_q    <= oen_d;
         lock_q   <= lock_d;
         trim_q   <= trim_d;
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Same trim to every synthesizer; each scales its rate by 1+X/2^32
   for (genvar s = 0; s < NUM_SYNTH; s++) begin : g_trim
      always_ff @(posedge clock) begin
         if (rst) begin
            trim_bc_q[s] <= TRIM_RST;
         end else begin
            trim_bc_q[s] <= signed'(trim_d);
         end
      end
   end

   // Feed the helpers
   assign cfg.fec_num  = fec_q[31:FEC_NUM_LSB];
   assign cfg.fec_den  = fec_q[FEC_NUM_LSB-1:0];
   assign cfg.base_hz  = base_rate_hz;
   assign cfg.base_mul = base_rate_multiplier;
   assign cfg.crit     = {lock_q[LOCK_B_LSB +: 2], lock_q[LOCK_A_LSB +: 2]};

   // Rate product pipeline
   scr_rate_calc u_rate (
      .clock (clock),
      .rst   (rst),
      .cfg   (cfg.rate)
   );

   // Lock criterion decoders
   scr_lock_decode u_lock (
      .clock (clock),
      .rst   (rst),
      .cfg   (cfg.lock)
   );

   // Outputs, all from flops
   assign reg_rdata               = rdata_q;
   assign reg_rvalid              = rvalid_q;
   assign synth_b_fec_numerator   = fec_q[31:FEC_NUM_LSB];
   assign synth_b_fec_denominator = fec_q[FEC_NUM_LSB-1:0];
   assign synth_b_rate_product    = cfg.rate_num;
   assign synth_a_loop_source     = src_q[SRC_A_BIT];
   assign synth_b_loop_source     = src_q[SRC_B_BIT];
   assign synth_a_out_en          = oen_q[OEN_A_BIT];
   assign synth_b_out_en          = oen_q[OEN_B_BIT];
   assign loop_a_lock_criterion   = lock_q[LOCK_A_LSB +: 2];
   assign loop_b_lock_criterion   = lock_q[LOCK_B_LSB +: 2];
   assign loop_a_phase_limit_us   = cfg.lim_us[0];
   assign loop_a_window_s         = cfg.win_s[0];
   assign loop_b_phase_limit_us   = cfg.lim_us[1];
   assign loop_b_window_s         = cfg.win_s[1];
   assign synth_rate_trim         = trim_bc_q;

   // Checks on the register file
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_reset_values: assert property ($past(rst) |-> synth_b_fec_numerator == 16'h0001
      && synth_b_fec_denominator == 16'h0001 && synth_b_loop_source
      && !synth_a_loop_source && synth_a_out_en && !synth_b_out_en)
      else $error("Wrong values after reset");
   a_trim_reset: assert property ($past(rst) |-> synth_rate_trim[0] == 32'h046AAAAB)
      else $error("Trim reset value wrong");
   a_src_follow: assert property (reg_wr && reg_addr == SRC_ADDR |=>
      synth_a_loop_source == $past(reg_wdata[0])
      && synth_b_loop_source == $past(reg_wdata[4]))
      else $error("Loop source not taken from write");
   a_oen_follow: assert property (reg_wr && reg_addr == OEN_ADDR |=>
      synth_a_out_en == $past(reg_wdata[0])
      && synth_b_out_en == $past(reg_wdata[2]))
      else $error("Output enable not taken from write");
   a_crit_follow: assert property (reg_wr && reg_addr == LOCK_ADDR |=>
      loop_b_lock_criterion == $past(reg_wdata[3:2])
      && loop_a_lock_criterion == $past(reg_wdata[1:0]))
      else $error("Lock criterion not taken from write");
   a_resv_read: assert property (reg_rd && reg_addr == LOCK_ADDR |=>
      reg_rvalid && reg_rdata[7:4] == 4'hA)
      else $error("Reserved lock bits changed");
   a_fec_split: assert property (reg_wr && reg_addr == FEC_ADDR |=>
      synth_b_fec_numerator[15:8] == $past(reg_wdata))
      else $error("Numerator top byte misplaced");
   a_trim_common: assert property (synth_rate_trim[0] == trim_q
      && synth_rate_trim[1] == trim_q && synth_rate_trim[2] == trim_q
      && synth_rate_trim[3] == trim_q)
      else $error("Trim copies differ");
   a_trim_low: assert property (reg_wr && reg_addr == TRIM_ADDR + 7'h03 |=>
      synth_rate_trim[2][7:0] == $past(reg_wdata))
      else $error("Trim low byte misplaced");

   // Main scenarios
   c_fec_write: cover property (reg_wr && reg_addr == FEC_ADDR + 7'h01);
   c_swap_loops: cover property (synth_a_loop_source && !synth_b_loop_source);
   c_both_on: cover property (synth_a_out_en && synth_b_out_en);
   c_neg_trim: cover property (synth_rate_trim[0][31]);
endmodule : scr_synth_cfg
